// [icc_regs.svh]
// register offsets, field positions and reset values of the capture channel
`ifndef ICC_REGS_SVH
`define ICC_REGS_SVH
`define ICC_OFF_CON      4'h0
`define ICC_OFF_CLR      4'h1
`define ICC_OFF_SET      4'h2
`define ICC_OFF_INV      4'h3
`define ICC_OFF_BUF      4'h4
`define ICC_BIT_ON       15
`define ICC_BIT_IDLE_STOP  13
`define ICC_BIT_FIRST_EDGE 9
`define ICC_BIT_WIDE     8
`define ICC_BIT_TMR      7
`define ICC_BIT_DECIM_LO 5
`define ICC_BIT_OV       4
`define ICC_BIT_BNE      3
`define ICC_CON_WMASK    16'ha3e7
`define ICC_CON_RESET    16'h0000
`define ICC_FIFO_DEPTH   4
`endif

// [icc_pkg.sv]
// types shared by the capture channel files
`default_nettype none
package icc_pkg;
	typedef enum logic [2:0] {
		ICC_OFF     = 3'b000,
		ICC_EDGES   = 3'b001,
		ICC_FALL    = 3'b010,
		ICC_RISE    = 3'b011,
		ICC_RISE4   = 3'b100,
		ICC_RISE16  = 3'b101,
		ICC_EVERY   = 3'b110,
		ICC_IRQONLY = 3'b111
	} icc_mode_t;
endpackage : icc_pkg
`default_nettype wire

// [icc_fifo.sv]
// small capture value fifo, oldest entry on the read port
`timescale 1ns/1ps
`default_nettype none
module icc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             clear_i,
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] data_i,
	input  wire logic             pop_i,
	output logic      [WIDTH-1:0] data_o,
	output logic                  empty_o,
	output logic                  full_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             do_push;
	logic             do_pop;

	// pointer arithmetic; a push into a full fifo is dropped
	always_comb begin
		do_push     = push_i && !full_o;
		do_pop      = pop_i && !empty_o;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (clear_i) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count  = '0;
		end else begin
			if (do_push)
				next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (do_pop)
				next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			next_count = count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
		end
	end

	// pointer registers
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// storage carries no reset, contents are unknown until written
	always_ff @(posedge clk_i) begin
		if (do_push && !clear_i)
			mem[wr_ptr] <= data_i;
	end

	assign data_o  = mem[rd_ptr];
	assign empty_o = (count == '0);
	assign full_o  = (count == (AW+1)'(DEPTH));
endmodule : icc_fifo
`default_nettype wire

// [icc_capture.sv]
// input capture channel: control register, edge modes and capture buffer
`timescale 1ns/1ps
`default_nettype none
`include "icc_regs.svh"
module icc_capture import icc_pkg::*; #(
	parameter int FIFO_DEPTH = `ICC_FIFO_DEPTH
) (
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_B_I,
	input  wire logic [3:0]  AVS_ADDRESS_I,
	input  wire logic        AVS_READ_I,
	input  wire logic        AVS_WRITE_I,
	input  wire logic [31:0] AVS_WRITEDATA_I,
	input  wire logic [3:0]  AVS_BYTEENABLE_I,
	output logic      [31:0] AVS_READDATA_O,
	output logic             AVS_WAITREQUEST_O,
	input  wire logic        CAPTURE_PIN_I,
	input  wire logic        IDLE_MODE_I,
	input  wire logic        SLEEP_MODE_I,
	input  wire logic [15:0] SECOND_GENERAL_TIMER_I,
	input  wire logic [15:0] THIRD_GENERAL_TIMER_I,
	input  wire logic [31:0] WIDE_TIMER_I,
	output logic             CAPTURE_IRQ_O
);
	// control register and its fields
	logic [15:0] ctrl;
	logic [15:0] next_ctrl;
	logic        enable;
	logic        idle_stop;
	logic        first_edge_select;
	logic        wide_capture_select;
	logic        timer_source_select;
	logic [1:0]  interrupt_decimation;
	icc_mode_t   capture_mode;
	logic        capture_overflow_flag;
	logic        buffer_not_empty_flag;

	// pin synchroniser and edge history
	logic        pin_meta;
	logic        pin_sync;
	logic        pin_prev;
	logic        rise;
	logic        fall;

	// capture state
	logic [3:0]  prescale;
	logic [3:0]  next_prescale;
	logic        first_done;
	logic        next_first_done;
	logic [1:0]  irq_count;
	logic [1:0]  next_irq_count;
	logic        overflow;
	logic        next_overflow;
	logic        irq;
	logic        next_irq;
	logic        run;
	logic        event_hit;
	logic        capture;
	logic [31:0] timer_value;

	// bus handshake
	logic        answered;
	logic        next_answered;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic        access;
	logic        bus_write;
	logic        pop;
	logic [31:0] fifo_data;
	logic        fifo_empty;
	logic        fifo_full;

	// merge written bytes over the current value
	function automatic logic [15:0] byte_merge(input logic [15:0] cur, input logic [31:0] wd,
		input logic [3:0] be);
		logic [15:0] res;
		res = cur;
		if (be[0])
			res[7:0] = wd[7:0];
		if (be[1])
			res[15:8] = wd[15:8];
		return res;
	endfunction : byte_merge

	assign enable               = ctrl[`ICC_BIT_ON];
	assign idle_stop            = ctrl[`ICC_BIT_IDLE_STOP];
	assign first_edge_select    = ctrl[`ICC_BIT_FIRST_EDGE];
	assign wide_capture_select  = ctrl[`ICC_BIT_WIDE];
	assign timer_source_select  = ctrl[`ICC_BIT_TMR];
	assign interrupt_decimation = ctrl[`ICC_BIT_DECIM_LO +: 2];
	assign capture_mode         = icc_mode_t'(ctrl[2:0]);
	assign capture_overflow_flag = overflow;
	assign buffer_not_empty_flag = !fifo_empty;

	// pin crosses two flops before any edge logic looks at it
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
		end else begin
			pin_meta <= CAPTURE_PIN_I;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign rise = pin_sync && !pin_prev;
	assign fall = !pin_sync && pin_prev;

	// running: enabled and not halted by idle
	assign run = enable && !(idle_stop && IDLE_MODE_I);

	// timer source choice
	always_comb begin
		if (wide_capture_select)
			timer_value = WIDE_TIMER_I;
		else if (timer_source_select)
			timer_value = {16'h0000, SECOND_GENERAL_TIMER_I};
		else
			timer_value = {16'h0000, THIRD_GENERAL_TIMER_I};
	end

	// edge qualification per mode and prescaler
	always_comb begin
		event_hit       = 1'b0;
		capture         = 1'b0;
		next_prescale   = prescale;
		next_first_done = first_done;
		unique case (capture_mode)
			ICC_OFF: begin
				next_prescale   = 4'h0;
				next_first_done = 1'b0;
			end
			ICC_EDGES: begin
				event_hit = rise || fall;
				capture   = event_hit;
			end
			ICC_FALL: begin
				event_hit = fall;
				capture   = event_hit;
			end
			ICC_RISE: begin
				event_hit = rise;
				capture   = event_hit;
			end
			ICC_RISE4: begin
				if (rise) begin
					event_hit     = (prescale[1:0] == 2'h3);
					next_prescale = {2'h0, prescale[1:0] + 2'h1};
				end
				capture = event_hit;
			end
			ICC_RISE16: begin
				if (rise) begin
					event_hit     = (prescale == 4'hf);
					next_prescale = prescale + 4'h1;
				end
				capture = event_hit;
			end
			ICC_EVERY: begin
				// first capture waits for the chosen edge only
				if (first_done)
					event_hit = rise || fall;
				else
					event_hit = first_edge_select ? rise : fall;
				if (event_hit)
					next_first_done = 1'b1;
				capture = event_hit;
			end
			ICC_IRQONLY: begin
				// no timer latch here; edge only wakes the core
				event_hit = (rise || fall) && (SLEEP_MODE_I || IDLE_MODE_I);
			end
		endcase
		if (!run) begin
			event_hit = 1'b0;
			capture   = 1'b0;
		end
		if (!enable) begin
			next_prescale   = 4'h0;
			next_first_done = 1'b0;
		end
	end

	// interrupt decimation and overflow; hardware set beats clear
	always_comb begin
		next_irq_count = irq_count;
		next_irq       = 1'b0;
		next_overflow  = overflow;
		if (!enable) begin
			next_irq_count = 2'h0;
			next_overflow  = 1'b0;
		end else if (event_hit) begin
			if (capture_mode == ICC_IRQONLY || irq_count == interrupt_decimation) begin
				next_irq       = 1'b1;
				next_irq_count = 2'h0;
			end else begin
				next_irq_count = irq_count + 2'h1;
			end
		end
		if (enable && !fifo_empty && pop)
			next_overflow = 1'b0;
		if (capture && fifo_full)
			next_overflow = 1'b1;
	end

	icc_fifo #(
		.WIDTH (32),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i   (CORE_CLK_I),
		.rst_b_i (RST_B_I),
		.clear_i (!enable),
		.push_i  (capture),
		.data_i  (timer_value),
		.pop_i   (pop),
		.data_o  (fifo_data),
		.empty_o (fifo_empty),
		.full_o  (fifo_full)
	);

	// bus: one wait cycle, answer registered on the second
	assign access    = (AVS_READ_I || AVS_WRITE_I) && !answered;
	assign bus_write = AVS_WRITE_I && access;
	assign pop       = AVS_READ_I && access && (AVS_ADDRESS_I == `ICC_OFF_BUF);
	assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !answered;

	// register writes through direct, clear, set and invert views
	always_comb begin
		next_ctrl = ctrl;
		if (bus_write) begin
			unique case (AVS_ADDRESS_I)
				`ICC_OFF_CON: next_ctrl = byte_merge(ctrl, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
				`ICC_OFF_CLR: next_ctrl = ctrl & ~byte_merge(16'h0000, AVS_WRITEDATA_I,
					AVS_BYTEENABLE_I);
				`ICC_OFF_SET: next_ctrl = ctrl | byte_merge(16'h0000, AVS_WRITEDATA_I,
					AVS_BYTEENABLE_I);
				`ICC_OFF_INV: next_ctrl = ctrl ^ byte_merge(16'h0000, AVS_WRITEDATA_I,
					AVS_BYTEENABLE_I);
				default: next_ctrl = ctrl;
			endcase
		end
		// status bits are not storage; unimplemented bits stay zero
		next_ctrl = next_ctrl & `ICC_CON_WMASK;
	end

	// read mux, unmapped reads answer zero
	always_comb begin
		next_answered = access;
		next_rdata    = rdata; // read data stands until the next read answer
		if (AVS_READ_I && access) begin
			unique case (AVS_ADDRESS_I)
				`ICC_OFF_CON, `ICC_OFF_CLR, `ICC_OFF_SET, `ICC_OFF_INV: begin
					next_rdata = {16'h0000, ctrl};
					next_rdata[`ICC_BIT_OV]  = capture_overflow_flag;
					next_rdata[`ICC_BIT_BNE] = buffer_not_empty_flag;
				end
				`ICC_OFF_BUF: next_rdata = fifo_empty ? 32'h0000_0000 : fifo_data;
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// state registers
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ctrl       <= `ICC_CON_RESET;
			prescale   <= 4'h0;
			first_done <= 1'b0;
			irq_count  <= 2'h0;
			overflow   <= 1'b0;
			irq        <= 1'b0;
			answered   <= 1'b0;
			rdata      <= 32'h0000_0000;
		end else begin
			ctrl       <= next_ctrl;
			prescale   <= next_prescale;
			first_done <= next_first_done;
			irq_count  <= next_irq_count;
			overflow   <= next_overflow;
			irq        <= next_irq;
			answered   <= next_answered;
			rdata      <= next_rdata;
		end
	end

	assign AVS_READDATA_O = rdata;
	assign CAPTURE_IRQ_O  = irq;
endmodule : icc_capture
`default_nettype wire

// [icc_partner.sv]
// partner model: shared timer counters and the external capture pin
`timescale 1ns/1ps
`default_nettype none
module icc_partner (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        run_i,
	input  wire logic        lvl_i,
	output logic             pin_o,
	output logic      [15:0] cnt_o,
	output logic      [15:0] second_o,
	output logic      [15:0] third_o,
	output logic      [31:0] wide_o
);
	// timers count only on request so each capture sees a known value
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			cnt_o <= 16'h0000;
		else if (run_i)
			cnt_o <= cnt_o + 16'h0001;
	end
	// distinct patterns per timer so a wrong source choice shows
	assign second_o = cnt_o;
	assign third_o  = cnt_o ^ 16'h5a5a;
	assign wide_o   = {~cnt_o, cnt_o};
	// push-pull source, the pin is never released
	assign pin_o    = lvl_i;
endmodule : icc_partner
`default_nettype wire

// [icc_capture_asserts.sv]
// concurrent checks on the capture channel ports
`timescale 1ns/1ps
`default_nettype none
module icc_capture_asserts #(
	parameter int FIFO_DEPTH = 4
) (
	input wire logic        CORE_CLK_I,
	input wire logic        RST_B_I,
	input wire logic [3:0]  AVS_ADDRESS_I,
	input wire logic        AVS_READ_I,
	input wire logic        AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0]  AVS_BYTEENABLE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic        AVS_WAITREQUEST_O,
	input wire logic        CAPTURE_PIN_I,
	input wire logic        IDLE_MODE_I,
	input wire logic        SLEEP_MODE_I,
	input wire logic [15:0] SECOND_GENERAL_TIMER_I,
	input wire logic [15:0] THIRD_GENERAL_TIMER_I,
	input wire logic [31:0] WIDE_TIMER_I,
	input wire logic        CAPTURE_IRQ_O
);
	logic [7:0] pin_hist;
	wire logic  req = AVS_READ_I | AVS_WRITE_I;
	// recent pin samples; an interrupt needs an edge among them
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
		if (!RST_B_I)
			pin_hist <= 8'h00;
		else
			pin_hist <= {pin_hist[6:0], CAPTURE_PIN_I};
	end
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);
	sequence req_start;
		req && !$past(req);
	endsequence
	sequence req_answer;
		req && !AVS_WAITREQUEST_O;
	endsequence
	wait_first_a: assert property (req_start |-> AVS_WAITREQUEST_O)
		else $error("waitrequest low in first cycle");
	wait_second_a: assert property (req_start |=> req_answer)
		else $error("no answer in second cycle");
	wait_idle_a: assert property (!req |-> !AVS_WAITREQUEST_O)
		else $error("waitrequest without request");
	rdata_hold_a: assert property ($changed(AVS_READDATA_O) |-> $past(AVS_READ_I && AVS_WAITREQUEST_O))
		else $error("read data moved outside a read");
	ctrl_zero_a: assert property (req_answer and AVS_READ_I && AVS_ADDRESS_I < 4'h4 |->
		AVS_READDATA_O[31:16] == 16'h0000 && AVS_READDATA_O[14] == 1'b0 && AVS_READDATA_O[12:10] == 3'h0)
		else $error("unimplemented control bits not zero");
	unmap_zero_a: assert property (req_answer and AVS_READ_I && AVS_ADDRESS_I > 4'h4 |-> AVS_READDATA_O == 32'h0)
		else $error("unmapped read not zero");
	irq_cause_a: assert property (CAPTURE_IRQ_O |-> pin_hist != 8'h00 && pin_hist != 8'hff)
		else $error("interrupt without a pin edge");
	irq_pulse_a: assert property (CAPTURE_IRQ_O |=> !CAPTURE_IRQ_O)
		else $error("interrupt longer than one cycle");
endmodule : icc_capture_asserts
bind icc_capture icc_capture_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the capture channel
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk, rst_b, rd, wr, idle, sleep, run, lvl, wait_req, irq, pin;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, q, v, tw;
	logic [15:0] t2, t3, cnt;
	int          err_count, n_compared, cyc, irq_seen, base, nc;
	// per case: control word, {sleep, idle}, captures and interrupts expected
	logic [15:0] c_ctrl [14] = '{16'h8121, 16'h80c2, 16'h8063, 16'h8004, 16'h8025, 16'h8206,
		16'h8006, 16'h8000, 16'h8007, 16'h8007, 16'h8007, 16'ha003, 16'h8003, 16'h0003};
	logic [1:0]  c_pm [14] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 2, 1, 1, 1, 0};
	int          c_cap [14] = '{32, 16, 16, 4, 1, 32, 31, 0, 0, 0, 0, 0, 16, 0};
	int          c_irq [14] = '{16, 5, 4, 4, 0, 32, 31, 0, 0, 32, 32, 0, 16, 0};
	icc_capture #(.FIFO_DEPTH(4)) dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(addr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
		.AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req), .CAPTURE_PIN_I(pin),
		.IDLE_MODE_I(idle), .SLEEP_MODE_I(sleep), .SECOND_GENERAL_TIMER_I(t2),
		.THIRD_GENERAL_TIMER_I(t3), .WIDE_TIMER_I(tw), .CAPTURE_IRQ_O(irq));
	icc_partner u_part (.clk_i(clk), .rst_b_i(rst_b), .run_i(run), .lvl_i(lvl), .pin_o(pin),
		.cnt_o(cnt), .second_o(t2), .third_o(t3), .wide_o(tw));
	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// one bus access; holds the request until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= ~w;
		// waitrequest is judged at rising edges only
		@(posedge clk);
		while (wait_req !== 1'b0 && n < 50) begin
			@(posedge clk);
			n++;
		end
		r = rdata;
		if (n >= 50)
			err_count++;
		wr <= 1'b0;
		rd <= 1'b0;
		// one idle edge between accesses, also after the enable bit is cleared
		@(posedge clk);
	endtask : bus
	task automatic access(input logic [3:0] a, input logic [31:0] d, input logic [3:0] ra,
		input logic [31:0] e);
		logic [31:0] r;
		bus(1'b1, a, d, r);
		bus(1'b0, ra, 32'h0, r);
		chk("register", e, r);
	endtask : access
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// interrupt pulse counter and the run time ceiling
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (irq === 1'b1)
			irq_seen <= irq_seen + 1;
		if (cyc == 30000) begin
			err_count++;
			tally_and_finish();
		end
	end
	initial begin
		{rst_b, rd, wr, idle, sleep, run, lvl} = 7'h0;
		{addr, wdata, cyc, irq_seen, err_count, n_compared} = '0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		bus(1'b0, 4'h0, 32'h0, q);
		chk("reset", 32'h0, q);
		access(4'h0, 32'hffffffff, 4'h0, 32'h0000a3e7);
		access(4'h1, 32'hffffffff, 4'h0, 32'h0);
		access(4'h2, 32'h00008005, 4'h0, 32'h00008005);
		access(4'h3, 32'h00000006, 4'h0, 32'h00008003);
		access(4'h4, 32'h12345678, 4'h4, 32'h0);
		access(4'h7, 32'hffffffff, 4'h9, 32'h0);
		for (int i = 0; i < 14; i++) begin
			bus(1'b1, 4'h0, 32'h0, q);
			run <= 1'b1;
			repeat (i + 2) @(posedge clk);
			run <= 1'b0;
			bus(1'b1, 4'h0, {16'h0, c_ctrl[i]}, q);
			{sleep, idle} <= c_pm[i];
			base = irq_seen;
			// 32 pin changes, spaced well past the synchroniser delay
			repeat (32) begin
				lvl <= ~lvl;
				repeat (6) @(posedge clk);
			end
			repeat (8) @(posedge clk);
			{sleep, idle} <= 2'b00;
			chk("irq count", 32'(c_irq[i]), 32'(irq_seen - base));
			v = {16'h0, c_ctrl[i] & 16'ha3e7};
			bus(1'b0, 4'h0, 32'h0, q);
			chk("status", v | (c_cap[i] > 0 ? 32'h8 : 32'h0) | (c_cap[i] > 4 ? 32'h10 : 32'h0), q);
			nc = c_cap[i] > 4 ? 4 : c_cap[i];
			for (int k = 0; k < nc; k++) begin
				bus(1'b0, 4'h4, 32'h0, q);
				chk("buffer", c_ctrl[i][8] ? {~cnt, cnt} : {16'h0, c_ctrl[i][7] ? cnt : cnt ^ 16'h5a5a}, q);
			end
			bus(1'b0, 4'h0, 32'h0, q);
			chk("drained", v, q);
		end
		// two rising edges with the timer moved between them; oldest comes out first
		bus(1'b1, 4'h0, 32'h0000_8103, q);
		repeat (2) begin
			lvl <= 1'b1;
			repeat (6) @(posedge clk);
			lvl <= 1'b0;
			run <= 1'b1;
			repeat (6) @(posedge clk);
			run <= 1'b0;
		end
		bus(1'b0, 4'h4, 32'h0, q);
		chk("fifo oldest", {~(cnt - 16'h000c), cnt - 16'h000c}, q);
		bus(1'b0, 4'h4, 32'h0, q);
		chk("fifo newer", {~(cnt - 16'h0006), cnt - 16'h0006}, q);
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
